// >>> mdsp_port.v
`include "mdsp_defines.vh"

module mdsp_port (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        sck_i,
  input  wire        sdi_i,
  input  wire        select_low_i,
  output reg         sdo_o,
  output wire        sdo_oe_n_o,
  input  wire [9:0]  mstep_pos_i,
  input  wire [9:0]  load_value_i,
  input  wire [4:0]  current_act_i,
  input  wire [7:0]  status_flags_i,
  output reg  [4:0]  write_strobe_o,
  output wire        coil_a_sign_o,
  output wire [7:0]  coil_a_magnitude_o,
  output wire        coil_b_sign_o,
  output wire [7:0]  coil_b_magnitude_o,
  output wire        interp_enable_o,
  output wire        both_edge_step_o,
  output wire [3:0]  microstep_resolution_o,
  output wire [1:0]  blank_time_o,
  output wire        chopper_mode_o,
  output wire        random_off_time_o,
  output wire [1:0]  hyst_decrement_o,
  output wire [3:0]  hyst_end_o,
  output wire [2:0]  hyst_start_o,
  output wire [3:0]  off_time_o,
  output wire        min_current_select_o,
  output wire [1:0]  decrement_rate_o,
  output wire [3:0]  upper_threshold_span_o,
  output wire [1:0]  increment_step_o,
  output wire [3:0]  lower_threshold_o,
  output wire        load_filter_enable_o,
  output wire [6:0]  load_threshold_o,
  output wire [4:0]  current_scale_o,
  output wire        test_mode_o,
  output wire [1:0]  high_side_slope_o,
  output wire [1:0]  low_side_slope_o,
  output wire        short_protect_disable_o,
  output wire [1:0]  short_detect_delay_o,
  output wire        step_dir_disable_o,
  output wire        sense_range_o,
  output wire [1:0]  readback_select_o
);

  parameter WORD_BITS = `MDSP_WORD_BITS;

  // ==========================================================
  // input synchronisers and glitch filter
  // ==========================================================
  // three stages per pin; a level counts once stages two and
  // three agree, so a pulse seen by one sample only is dropped
  reg [2:0] sck_s;
  reg [2:0] sdi_s;
  reg [2:0] sel_s;
  reg       sck_f;
  reg       sdi_f;
  reg       sel_f;
  reg       sck_d;
  reg       sel_d;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      sel_s <= 3'h7;
      sck_f <= 1'b0;
      sdi_f <= 1'b0;
      sel_f <= 1'b1;
      sck_d <= 1'b0;
      sel_d <= 1'b1;
    end else begin
      sck_s <= {sck_s[1:0], sck_i};
      sdi_s <= {sdi_s[1:0], sdi_i};
      sel_s <= {sel_s[1:0], select_low_i};
      if (sck_s[1] == sck_s[2])
        sck_f <= sck_s[2];
      if (sdi_s[1] == sdi_s[2])
        sdi_f <= sdi_s[2];
      if (sel_s[1] == sel_s[2])
        sel_f <= sel_s[2];
      sck_d <= sck_f;
      sel_d <= sel_f;
    end
  end

  wire sck_rise = sck_f & ~sck_d & ~sel_f;
  wire sck_fall = ~sck_f & sck_d & ~sel_f;
  wire sel_fall = ~sel_f & sel_d;
  wire sel_rise = sel_f & ~sel_d;

  // ==========================================================
  // registers
  // ==========================================================
  // only bits 17:0 are stored; for the three-bit selects bit 17 is an address bit
  reg [17:0] drive_control;
  reg [17:0] chopper_config;
  reg [17:0] current_adapt_config;
  reg [17:0] load_detect_config;
  reg [17:0] driver_config;

  // ==========================================================
  // status response
  // ==========================================================
  function [19:0] resp_word;
    input [1:0] rsel;
    input [9:0] mstep;
    input [9:0] load;
    input [4:0] act;
    input [7:0] flags;
    begin
      if (rsel == `MDSP_RD_MSTEP)
        resp_word = {mstep, 2'b00, flags};
      else if (rsel == `MDSP_RD_LOAD)
        resp_word = {load, 2'b00, flags};
      else
        resp_word = {load[9:5], act, 2'b00, flags};
    end
  endfunction

  wire [1:0] rsel = driver_config[`MDSP_DC_READBACK_SELECT];
  wire [19:0] resp_now = resp_word(rsel, mstep_pos_i, load_value_i,
                                   current_act_i, status_flags_i);

  // ==========================================================
  // shift register and transaction control
  // ==========================================================
  reg [WORD_BITS-1:0]     shift;
  reg [`MDSP_CNT_BITS-1:0] bit_cnt;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      shift   <= {WORD_BITS{1'b0}};
      bit_cnt <= {`MDSP_CNT_BITS{1'b0}};
      sdo_o   <= 1'b0;
    end else if (sel_fall) begin
      // response loaded at frame start; the msb is out at once
      shift   <= resp_now;
      sdo_o   <= resp_now[19];
      bit_cnt <= {`MDSP_CNT_BITS{1'b0}};
    end else begin
      if (sck_rise) begin
        // older bits fall off the top: only the last 20 stay
        shift <= {shift[WORD_BITS-2:0], sdi_f};
        if (bit_cnt != WORD_BITS[`MDSP_CNT_BITS-1:0])
          bit_cnt <= bit_cnt + 5'h01;
      end
      if (sck_fall)
        sdo_o <= shift[WORD_BITS-1];
    end
  end

  assign sdo_oe_n_o = sel_f;

  // ==========================================================
  // command commit and register decode
  // ==========================================================
  // a short frame is dropped: a partial word would land in the
  // wrong register with stale high bits
  wire commit = sel_rise &
                (bit_cnt == WORD_BITS[`MDSP_CNT_BITS-1:0]);
  wire [2:0] top = shift[19:17];

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      drive_control        <= `MDSP_REG_RESET;
      chopper_config       <= `MDSP_REG_RESET;
      current_adapt_config <= `MDSP_REG_RESET;
      load_detect_config   <= `MDSP_REG_RESET;
      driver_config        <= `MDSP_REG_RESET;
      write_strobe_o       <= 5'h00;
    end else begin
      write_strobe_o <= 5'h00;
      if (commit) begin
        if (top[2:1] == `MDSP_SEL2_DRV) begin
          drive_control     <= shift[17:0];
          write_strobe_o[0] <= 1'b1;
        end else if (top == `MDSP_SEL3_CHOP) begin
          chopper_config    <= shift[17:0];
          write_strobe_o[1] <= 1'b1;
        end else if (top == `MDSP_SEL3_ADAPT) begin
          current_adapt_config <= shift[17:0];
          write_strobe_o[2]    <= 1'b1;
        end else if (top == `MDSP_SEL3_LOAD) begin
          load_detect_config <= shift[17:0];
          write_strobe_o[3]  <= 1'b1;
        end else begin
          driver_config     <= shift[17:0];
          write_strobe_o[4] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // field views
  // ==========================================================
  wire sdd = driver_config[`MDSP_DC_STEP_DIR_DISABLE];

  // coil fields only mean something in serial mode, step fields
  // only in step mode; the unused view reads as zero
  assign coil_a_sign_o      = sdd & drive_control[`MDSP_DRV_A_SIGN];
  assign coil_a_magnitude_o = {8{sdd}} & drive_control[`MDSP_DRV_A_MAG];
  assign coil_b_sign_o      = sdd & drive_control[`MDSP_DRV_B_SIGN];
  assign coil_b_magnitude_o = {8{sdd}} & drive_control[`MDSP_DRV_B_MAG];
  assign interp_enable_o    = ~sdd & drive_control[`MDSP_DRV_INTERP];
  assign both_edge_step_o   = ~sdd & drive_control[`MDSP_DRV_BOTH_EDGE_STEP];
  assign microstep_resolution_o =
    {4{~sdd}} & drive_control[`MDSP_DRV_MICROSTEP_RESOLUTION];

  assign blank_time_o      = chopper_config[`MDSP_CHP_BLANK];
  assign chopper_mode_o    = chopper_config[`MDSP_CHP_MODE];
  assign random_off_time_o = chopper_config[`MDSP_CHP_RND];
  assign hyst_decrement_o  = chopper_config[`MDSP_CHP_HYST_DECREMENT];
  assign hyst_end_o        = chopper_config[`MDSP_CHP_HYST_END];
  assign hyst_start_o      = chopper_config[`MDSP_CHP_HYST_START];
  assign off_time_o        = chopper_config[`MDSP_CHP_OFF_TIME];

  assign min_current_select_o =
    current_adapt_config[`MDSP_ADP_IMIN];
  assign decrement_rate_o = current_adapt_config[`MDSP_ADP_DN];
  assign upper_threshold_span_o =
    current_adapt_config[`MDSP_ADP_MAX];
  assign increment_step_o  = current_adapt_config[`MDSP_ADP_UP];
  assign lower_threshold_o = current_adapt_config[`MDSP_ADP_MIN];

  assign load_filter_enable_o = load_detect_config[`MDSP_LD_FILT];
  assign load_threshold_o     = load_detect_config[`MDSP_LD_THR];
  assign current_scale_o      = load_detect_config[`MDSP_LD_CS];

  assign test_mode_o          = driver_config[`MDSP_DC_TEST];
  assign high_side_slope_o    = driver_config[`MDSP_DC_HIGH_SIDE_SLOPE];
  assign low_side_slope_o     = driver_config[`MDSP_DC_LOW_SIDE_SLOPE];
  assign short_protect_disable_o = driver_config[`MDSP_DC_DISS];
  assign short_detect_delay_o = driver_config[`MDSP_DC_SHORT_DETECT_DELAY];
  assign step_dir_disable_o   = sdd;
  assign sense_range_o        = driver_config[`MDSP_DC_SENSE_RANGE];
  assign readback_select_o    = rsel;

endmodule

// >>> mdsp_defines.vh
// Notes on behaviour
// - act only while select_low is low
// - sample data on rising clock, drive after falling
// - most significant bit first both directions
// - extra bits emerge 20 clocks later
// - select rise latches shift register as command (code latches only if 20 or more clocks came in the frame)
// - only last 20 bits count
// - reject input pulses shorter than 20ns
// - each command writes one of five registers
// - top bits 00,100,101,110,111 select register
// - coil sign and magnitude fields in SPI mode
// - interpolation, edge and resolution in step mode
// - chopper config field layout
// - current adaptation field layout
// - load detect field layout
// - driver config field layout
// - readback_select chooses response content
// - response 00: position high, flags low
// - current_scale zero after power-up
`ifndef MDSP_DEFINES_VH
`define MDSP_DEFINES_VH
`define MDSP_WORD_BITS    20
`define MDSP_CNT_BITS     5
`define MDSP_FILT_NS      20
`define MDSP_CLK_NS       40
`define MDSP_FILT_CYC     ((`MDSP_FILT_NS+`MDSP_CLK_NS-1)/`MDSP_CLK_NS)
`define MDSP_SEL2_DRV     2'b00
`define MDSP_SEL3_CHOP    3'b100
`define MDSP_SEL3_ADAPT   3'b101
`define MDSP_SEL3_LOAD    3'b110
`define MDSP_SEL3_DRIVER_CONFIG 3'b111
`define MDSP_REG_RESET    18'h00000
`define MDSP_DRV_A_SIGN   17
`define MDSP_DRV_A_MAG    16:9
`define MDSP_DRV_B_SIGN   8
`define MDSP_DRV_B_MAG    7:0
`define MDSP_DRV_INTERP   9
`define MDSP_DRV_BOTH_EDGE_STEP    8
`define MDSP_DRV_MICROSTEP_RESOLUTION     3:0
`define MDSP_CHP_BLANK    16:15
`define MDSP_CHP_MODE     14
`define MDSP_CHP_RND      13
`define MDSP_CHP_HYST_DECREMENT     12:11
`define MDSP_CHP_HYST_END     10:7
`define MDSP_CHP_HYST_START    6:4
`define MDSP_CHP_OFF_TIME     3:0
`define MDSP_ADP_IMIN     15
`define MDSP_ADP_DN       14:13
`define MDSP_ADP_MAX      11:8
`define MDSP_ADP_UP       6:5
`define MDSP_ADP_MIN      3:0
`define MDSP_LD_FILT      16
`define MDSP_LD_THR       14:8
`define MDSP_LD_CS        4:0
`define MDSP_DC_TEST      16
`define MDSP_DC_HIGH_SIDE_SLOPE      15:14
`define MDSP_DC_LOW_SIDE_SLOPE      13:12
`define MDSP_DC_DISS      10
`define MDSP_DC_SHORT_DETECT_DELAY      9:8
`define MDSP_DC_STEP_DIR_DISABLE     7
`define MDSP_DC_SENSE_RANGE    6
`define MDSP_DC_READBACK_SELECT     5:4
`define MDSP_RD_MSTEP     2'b00
`define MDSP_RD_LOAD      2'b01
`endif

// >>> mdsp_props.sv
module mdsp_props (
  input logic       clk_sys_i,
  input logic       rst_i,
  input logic       select_low_i,
  input logic       sdo_oe_n_o,
  input logic [4:0] write_strobe_o,
  input logic [4:0] current_scale_o,
  input logic [3:0] off_time_o,
  input logic [1:0] readback_select_o,
  input logic       step_dir_disable_o,
  input logic [7:0] coil_a_magnitude_o,
  input logic       interp_enable_o
);
  // ========
  // select edges and their consequences
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence sel_fall;
    $fell(select_low_i);
  endsequence
  sequence sel_rise;
    $rose(select_low_i);
  endsequence
  AST_OE_ON: assert property (sel_fall |-> ##[3:6] !sdo_oe_n_o)
    else $error("sdo not driven after select fall");
  AST_OE_OFF: assert property (sel_rise |-> ##[3:6] sdo_oe_n_o)
    else $error("sdo still driven after select rise");
  AST_ONE_TARGET: assert property ($onehot0(write_strobe_o))
    else $error("several registers written at once");
  AST_STROBE_LATE: assert property (|write_strobe_o |->
    select_low_i && $past(select_low_i, 3))
    else $error("write without select rise");
  AST_STROBE_ONCE: assert property (|write_strobe_o |=> !write_strobe_o)
    else $error("write strobe longer than one cycle");
  AST_QUIET_SEL: assert property ((!select_low_i) [*8] |-> !write_strobe_o)
    else $error("write while selected");
  // fields may only move together with their own register's strobe
  AST_SCALE_HOLD: assert property ($changed(current_scale_o) |->
    write_strobe_o[3] || $past(write_strobe_o[3]))
    else $error("current scale moved without write");
  AST_CHOP_HOLD: assert property ($changed(off_time_o) |->
    write_strobe_o[1] || $past(write_strobe_o[1]))
    else $error("off time moved without write");
  AST_READBACK_SELECT_HOLD: assert property ($changed(readback_select_o) |->
    write_strobe_o[4] || $past(write_strobe_o[4]))
    else $error("readback select moved without write");
  AST_STEP_VIEW: assert property (!step_dir_disable_o |->
    coil_a_magnitude_o == 8'h00)
    else $error("coil field shown in step mode");
  AST_SPI_VIEW: assert property (step_dir_disable_o |-> !interp_enable_o)
    else $error("step field shown in coil mode");
endmodule

bind mdsp_port mdsp_props u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .select_low_i(select_low_i),
  .sdo_oe_n_o(sdo_oe_n_o), .write_strobe_o(write_strobe_o),
  .current_scale_o(current_scale_o), .off_time_o(off_time_o),
  .readback_select_o(readback_select_o),
  .step_dir_disable_o(step_dir_disable_o),
  .coil_a_magnitude_o(coil_a_magnitude_o),
  .interp_enable_o(interp_enable_o));

// >>> mdsp_master.sv
module mdsp_master (
  input  wire  clk_sys_i,
  input  wire  sdo_i,
  output logic sck_o,
  output logic sdi_o,
  output logic select_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // bus master, half period of 4 system clocks
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b1;
    select_low_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic xfer(input logic [31:0] d, input int n, input bit g,
                      output logic [31:0] r);
    r = '0;
    select_low_o <= 1'b0;
    wt(8);
    if (g) begin
      sck_o <= 1'b1; // one sample only, must be filtered out
      wt(1);
      sck_o <= 1'b0;
    end
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= d[i];
      wt(4);
      sck_o <= 1'b1;
      wt(4);
      r = {r[30:0], sdo_i};
      sck_o <= 1'b0;
    end
    wt(4);
    sdi_o <= ~sdi_o; // released line shows no stale bit
    select_low_o <= 1'b1;
    wt(12);
  endtask
endmodule

// >>> test_motor_driver_serial_config_port.sv
module test_motor_driver_serial_config_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i, rst_i, sck_i, sdi_i, select_low_i, sdo_o;
  logic        sdo_oe_n_o, coil_a_sign_o, coil_b_sign_o, interp_enable_o;
  logic        both_edge_step_o, chopper_mode_o, random_off_time_o;
  logic        min_current_select_o, load_filter_enable_o, test_mode_o;
  logic        short_protect_disable_o, step_dir_disable_o, sense_range_o;
  logic [9:0]  mstep_pos_i, load_value_i;
  logic [7:0]  status_flags_i, coil_a_magnitude_o, coil_b_magnitude_o;
  logic [6:0]  load_threshold_o;
  logic [4:0]  current_act_i, write_strobe_o, current_scale_o, seen;
  logic [3:0]  microstep_resolution_o, hyst_end_o, off_time_o;
  logic [3:0]  upper_threshold_span_o, lower_threshold_o;
  logic [2:0]  hyst_start_o;
  logic [1:0]  blank_time_o, hyst_decrement_o, decrement_rate_o;
  logic [1:0]  increment_step_o, high_side_slope_o, low_side_slope_o;
  logic [1:0]  short_detect_delay_o, readback_select_o;
  logic [19:0] w, m;
  logic [31:0] rx;
  int          err_total, checks;
  logic [19:0] adr [5] = '{20'h0, 20'h80000, 20'ha0000, 20'hc0000, 20'he0000};
  logic [19:0] msk [5] = '{20'h0, 20'h1ffff, 20'h0ef6f, 20'h17f1f, 20'h1f7f0};
  logic [19:0] pat [2] = '{20'h5a5a5, 20'ha5a5a};

  mdsp_port uut (.*);
  mdsp_master bus (.clk_sys_i(clk_sys_i), .sdo_i(sdo_o), .sck_o(sck_i),
                   .sdi_o(sdi_i), .select_low_o(select_low_i));
  // ========
  // clock, strobe catcher, helpers
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (|write_strobe_o) seen <= write_strobe_o;
  task automatic chk(input string s, input logic [19:0] e, input logic [19:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] d, input int n, input bit g);
    @(posedge clk_sys_i);
    seen <= '0;
    bus.xfer(d, n, g, rx);
  endtask
  // outputs placed back at their command bit positions
  function automatic logic [19:0] view(input int r);
    case (r)
      0: view = step_dir_disable_o ? {2'b00, coil_a_sign_o, coil_a_magnitude_o,
                coil_b_sign_o, coil_b_magnitude_o} : {10'h0, interp_enable_o,
                both_edge_step_o, 4'h0, microstep_resolution_o};
      1: view = {3'h0, blank_time_o, chopper_mode_o, random_off_time_o,
                hyst_decrement_o, hyst_end_o, hyst_start_o, off_time_o};
      2: view = {4'h0, min_current_select_o, decrement_rate_o, 1'b0,
                upper_threshold_span_o, 1'b0, increment_step_o, 1'b0,
                lower_threshold_o};
      3: view = {3'h0, load_filter_enable_o, 1'b0, load_threshold_o, 3'h0,
                current_scale_o};
      default: view = {3'h0, test_mode_o, high_side_slope_o, low_side_slope_o,
                1'b0, short_protect_disable_o, short_detect_delay_o,
                step_dir_disable_o, sense_range_o, readback_select_o, 4'h0};
    endcase
  endfunction
  function automatic logic [19:0] resp(input int k);
    if (k == 0) resp = {mstep_pos_i, 2'b00, status_flags_i};
    else if (k == 1) resp = {load_value_i, 2'b00, status_flags_i};
    else resp = {load_value_i[9:5], current_act_i, 2'b00, status_flags_i};
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2ms;
    err_total++;
    end_sim();
  end
  // ========
  // main sequence
  initial begin
    rst_i = 1'b1;
    seen = '0;
    mstep_pos_i = 10'h2c7;
    load_value_i = 10'h1b9;
    current_act_i = 5'h16;
    status_flags_i = 8'h96;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus.wt(4);
    chk("current_scale", 20'h0, {15'h0, current_scale_o});
    chk("sdo_oe_n", 20'h1, {19'h0, sdo_oe_n_o});
    $display("reset test done");
    foreach (pat[p]) begin
      for (int r = 4; r >= 0; r--) begin
        m = (r == 0) ? (pat[p][7] ? 20'h3ffff : 20'h0030f) : msk[r];
        w = adr[r] | (pat[p] & m);
        wr({12'h0, w}, 20, 1'b0);
        chk("strobe", {15'h0, 5'h01 << r}, {15'h0, seen});
        chk("fields", w & m, view(r));
      end
      $display("register pass %0d done", p);
    end
    for (int k = 0; k < 4; k++) begin
      wr(32'h000e0080 | (k << 4), 20, 1'b0);
      @(posedge clk_sys_i);
      status_flags_i <= status_flags_i + 8'h31;
      mstep_pos_i <= mstep_pos_i + 10'h0a3;
      wr(32'h00080000, 20, 1'b0);
      chk("response", resp(k), rx[19:0]);
    end
    $display("response test done");
    wr({4'h0, 8'h3c, 20'h81234}, 28, 1'b1);
    chk("last_bits", 20'h01234, view(1));
    chk("echo", 20'h0003c, {12'h0, rx[7:0]});
    wr(32'h00000fff, 12, 1'b0);
    chk("short_strobe", 20'h0, {15'h0, seen});
    chk("short_kept", 20'h01234, view(1));
    $display("chain test done");
    rst_i <= 1'b1;
    bus.wt(12);
    rst_i <= 1'b0;
    bus.wt(4);
    chk("current_scale_rst", 20'h0, {15'h0, current_scale_o});
    chk("load_rst", 20'h0, view(3));
    $display("mid reset test done");
    end_sim();
  end
endmodule
